// File: verilog/dlss_top.sv
// dlss_top: two channel load switch start-up, breaker and lockout sequencer.
// assumes digital comparator inputs from the analog front end and an apb master.
`timescale 1ns/1ps
module dlss_top
  import dlss_pkg::*;
#(
  parameter int UV_T    = UV_TICKS,
  parameter int DEB_T   = DEB_TICKS,
  parameter int BLANK_T = BLANK_TICKS,
  parameter int COOL_T  = COOL_TICKS
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [dlss_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      vcc_hi_ok,
  input  wire logic [dlss_pkg::NCH-1:0]  channel_supply_ok,
  input  wire logic [dlss_pkg::NCH-1:0]  chan_enable_n,
  input  wire logic [dlss_pkg::NCH-1:0]  breaker_trip,
  input  wire logic [dlss_pkg::NCH-1:0]  severe_short,
  output logic      [dlss_pkg::NCH-1:0]  gate_charge_on,
  output logic      [dlss_pkg::NCH-1:0]  gate_pulldown_on,
  output logic      [dlss_pkg::NCH-1:0]  gate_fast_pulldown_on,
  output logic                           fault_n_o,
  output logic                           fault_n_oe
);
  import dlss_pkg::*;

  localparam logic [TMR_W-1:0] UV_END    = TMR_W'(UV_T - 1);
  localparam logic [TMR_W-1:0] DEB_END   = TMR_W'(DEB_T - 1);
  localparam logic [TMR_W-1:0] BLANK_END = TMR_W'(BLANK_T - 1);
  localparam logic [TMR_W-1:0] COOL_END  = TMR_W'(COOL_T - 1);
  localparam logic [PRE_W-1:0] PRE_LAST  = PRE_W'(TICK_CYC - 1);

  typedef struct packed {
    logic [PRE_W-1:0]   pre;
    logic               tick;
    logic               uv_ready;
    logic [TMR_W-1:0]   uv_cnt;
    logic               auto_retry;
    logic [31:0]        rdata;
    dlss_ch_t [NCH-1:0] ch;
  } dlss_state_t;

  dlss_state_t s_q;
  dlss_state_t s_d;

  logic             hi_low;
  logic             hi_lock;
  logic [NCH-1:0]   en_high;
  logic [NCH-1:0]   en_clr;
  logic [NCH-1:0]   sup_low;
  logic [NCH-1:0]   sup_uv;
  logic [NCH-1:0]   oc_lvl;
  logic [NCH-1:0]   oc_q;
  logic [NCH-1:0]   sev;
  logic [NCH-1:0]   latched;
  logic             wr_en;
  logic             rd_setup;
  logic             mapped;

  // every asynchronous input is synchronised here; all but severe_short are also qualified
  dlss_flt_if u_hi_if ();
  assign u_hi_if.raw  = ~vcc_hi_ok;
  assign u_hi_if.tick = s_q.tick;
  assign hi_low       = u_hi_if.level;
  assign hi_lock      = u_hi_if.qual;
  dlss_filter #(.N(HI_UV_TICKS)) u_hi_flt (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (u_hi_if)
  );

  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_ch
      dlss_flt_if u_en_if ();
      dlss_flt_if u_sup_if ();
      dlss_flt_if u_oc_if ();
      dlss_flt_if u_sev_if ();
      assign u_en_if.raw   = chan_enable_n[gc];
      assign u_en_if.tick  = s_q.tick;
      assign u_sup_if.raw  = ~channel_supply_ok[gc];
      assign u_sup_if.tick = s_q.tick;
      assign u_oc_if.raw   = breaker_trip[gc];
      assign u_oc_if.tick  = s_q.tick;
      assign u_sev_if.raw  = severe_short[gc];
      assign u_sev_if.tick = s_q.tick;
      assign en_high[gc]   = u_en_if.level;
      assign en_clr[gc]    = u_en_if.qual;
      assign sup_low[gc]   = u_sup_if.level;
      assign sup_uv[gc]    = u_sup_if.qual;
      assign oc_lvl[gc]    = u_oc_if.level;
      assign oc_q[gc]      = u_oc_if.qual;
      assign sev[gc]       = u_sev_if.level;
      dlss_filter #(.N(EN_CLR_TICKS)) u_en_flt (
        .pclk    (pclk),
        .presetn (presetn),
        .f       (u_en_if)
      );
      dlss_filter #(.N(CH_UV_TICKS)) u_sup_flt (
        .pclk    (pclk),
        .presetn (presetn),
        .f       (u_sup_if)
      );
      dlss_filter #(.N(OC_TICKS)) u_oc_flt (
        .pclk    (pclk),
        .presetn (presetn),
        .f       (u_oc_if)
      );
      dlss_filter #(.N(1)) u_sev_flt (
        .pclk    (pclk),
        .presetn (presetn),
        .f       (u_sev_if)
      );
      assign latched[gc]               = (s_q.ch[gc].st == CH_LATCHED);
      assign gate_charge_on[gc]        = s_q.ch[gc].drive;
      assign gate_pulldown_on[gc]      = s_q.ch[gc].pdn;
      assign gate_fast_pulldown_on[gc] = s_q.ch[gc].fast;
    end
  endgenerate

  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped   = (paddr == CTRL_OFS) || (paddr == STATUS_OFS);

  always_comb begin
    dlss_ch_t    nxt;
    logic [31:0] st_word;
    nxt     = '0;
    st_word = '0;
    s_d     = s_q;

    // free-running 1 us time base
    s_d.tick = (s_q.pre == PRE_LAST);
    s_d.pre  = s_d.tick ? '0 : s_q.pre + PRE_W'(1);

    // lockout of the higher supply and its turn-on delay
    if (hi_lock) begin
      s_d.uv_ready = 1'h0;
      s_d.uv_cnt   = '0;
    end else if (!s_q.uv_ready) begin
      if (hi_low) begin
        s_d.uv_cnt = '0;
      end else if (s_q.tick) begin
        if (s_q.uv_cnt == UV_END) begin
          s_d.uv_ready = 1'h1;
        end else begin
          s_d.uv_cnt = s_q.uv_cnt + TMR_W'(1);
        end
      end
    end

    // one independent sequencer per channel
    for (int c = 0; c < NCH; c++) begin
      nxt = s_q.ch[c];
      if (!s_q.uv_ready || hi_lock) begin
        nxt.st  = CH_OFF;
        nxt.cnt = '0;
      end else if (sup_uv[c]) begin
        nxt.st  = CH_OFF;
        nxt.cnt = '0;
      end else begin
        unique case (s_q.ch[c].st)
          CH_OFF: begin
            if (!sup_low[c] && !en_high[c]) begin
              nxt.st  = CH_DEBOUNCE;
              nxt.cnt = '0;
            end
          end
          CH_DEBOUNCE: begin
            if (sup_low[c] || en_high[c]) begin
              nxt.st  = CH_OFF;
              nxt.cnt = '0;
            end else if (s_q.tick) begin
              if (s_q.ch[c].cnt == DEB_END) begin
                nxt.st  = CH_START;
                nxt.cnt = '0;
              end else begin
                nxt.cnt = s_q.ch[c].cnt + TMR_W'(1);
              end
            end
          end
          CH_START: begin
            if (en_high[c]) begin
              nxt.st  = CH_OFF;
              nxt.cnt = '0;
            end else if (s_q.tick) begin
              if (s_q.ch[c].cnt == BLANK_END) begin
                nxt.st  = oc_lvl[c] ? CH_LATCHED : CH_IDLE;
                nxt.cnt = '0;
              end else begin
                nxt.cnt = s_q.ch[c].cnt + TMR_W'(1);
              end
            end
          end
          CH_IDLE: begin
            if (en_high[c]) begin
              nxt.st  = CH_OFF;
              nxt.cnt = '0;
            end else if (oc_q[c]) begin
              nxt.st  = CH_CB_BLANK;
              nxt.cnt = '0;
            end
          end
          CH_CB_BLANK: begin
            if (en_high[c]) begin
              nxt.st  = CH_OFF;
              nxt.cnt = '0;
            end else if (s_q.tick) begin
              if (s_q.ch[c].cnt == BLANK_END) begin
                nxt.st  = CH_CB_ARMED;
                nxt.cnt = '0;
              end else begin
                nxt.cnt = s_q.ch[c].cnt + TMR_W'(1);
              end
            end
          end
          CH_CB_ARMED: begin
            if (en_high[c]) begin
              nxt.st  = CH_OFF;
              nxt.cnt = '0;
            end else if (oc_q[c]) begin
              nxt.st  = CH_LATCHED;
              nxt.cnt = '0;
            end else if (s_q.tick) begin
              if (s_q.ch[c].cnt == BLANK_END) begin
                nxt.st  = CH_IDLE;
                nxt.cnt = '0;
              end else begin
                nxt.cnt = s_q.ch[c].cnt + TMR_W'(1);
              end
            end
          end
          CH_LATCHED: begin
            if (en_clr[c]) begin
              nxt.st  = CH_OFF;
              nxt.cnt = '0;
            end else if (s_q.auto_retry && s_q.tick) begin
              if (s_q.ch[c].cnt == COOL_END) begin
                nxt.st  = CH_OFF;
                nxt.cnt = '0;
              end else begin
                nxt.cnt = s_q.ch[c].cnt + TMR_W'(1);
              end
            end
          end
          default: begin
            nxt.st  = CH_OFF;
            nxt.cnt = '0;
          end
        endcase
      end
      // latched exits only by the clears above, en_clr, or the cool-down when auto_retry is set
      nxt.drive = nxt.st inside {CH_START, CH_IDLE, CH_CB_BLANK, CH_CB_ARMED};
      nxt.pdn   = !nxt.drive;
      // fast pulldown only while the severe comparator fires; limiting then resumes
      nxt.fast  = nxt.drive && sev[c];
      s_d.ch[c] = nxt;
    end

    // apb: write control, read data latched in the setup phase
    if (wr_en && paddr == CTRL_OFS) begin
      s_d.auto_retry = pwdata[CTRL_RETRY_BIT];
    end
    st_word[ST_UV_BIT] = s_q.uv_ready;
    for (int c = 0; c < NCH; c++) begin
      st_word[ST_FLT_LSB + c] = latched[c];
      st_word[ST_DRV_LSB + c] = s_q.ch[c].drive;
      st_word[ST_DEB_LSB + c] = (s_q.ch[c].st == CH_DEBOUNCE);
    end
    if (rd_setup) begin
      if (paddr == CTRL_OFS) begin
        s_d.rdata                 = 32'h0000_0000;
        s_d.rdata[CTRL_RETRY_BIT] = s_q.auto_retry;
      end else if (paddr == STATUS_OFS) begin
        s_d.rdata = st_word;
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q            <= '0;
      s_q.auto_retry <= CTRL_RETRY_RST;
      for (int c = 0; c < NCH; c++) begin
        s_q.ch[c].pdn <= 1'h1;
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata     = s_q.rdata;
  assign pready     = 1'h1;
  assign pslverr    = psel && penable && (!mapped || (pwrite && paddr == STATUS_OFS));
  assign fault_n_o  = 1'h0;
  assign fault_n_oe = |latched;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_uv_hold_off: assert property (!s_q.uv_ready |-> ##1 gate_charge_on == '0)
    else $error("gate driven before lockout delay done");
  a_deb_abort: assert property ((s_q.ch[0].st == CH_DEBOUNCE && en_high[0])
                                |=> s_q.ch[0].st == CH_OFF)
    else $error("debounce not abandoned on enable high");
  a_deb_start: assert property ((s_q.ch[1].st == CH_OFF && s_q.uv_ready && !hi_lock
                                 && !sup_uv[1] && !sup_low[1] && !en_high[1])
                                |=> s_q.ch[1].st == CH_DEBOUNCE)
    else $error("debounce not started");
  a_turn_on: assert property ($rose(s_q.ch[0].st == CH_START)
                              |-> gate_charge_on[0] && !gate_pulldown_on[0])
    else $error("gate not charged at turn-on");
  a_en_off: assert property ((en_high[0] && s_q.ch[0].st != CH_LATCHED)
                             |=> gate_pulldown_on[0])
    else $error("enable high did not pull gate down");
  a_blank_hold: assert property ((s_q.ch[0].st == CH_START && s_q.ch[0].cnt != BLANK_END)
                                 |=> s_q.ch[0].st != CH_LATCHED)
    else $error("latched inside start-up blanking");
  a_start_latch: assert property ((s_q.ch[0].st == CH_START && s_q.tick && oc_lvl[0]
                                   && s_q.ch[0].cnt == BLANK_END && !en_high[0]
                                   && !sup_uv[0] && !hi_lock && s_q.uv_ready)
                                  |=> latched[0] && fault_n_oe)
    else $error("no latch-off after start-up blanking");
  a_oc_ignore: assert property ((s_q.ch[0].st == CH_IDLE && !oc_q[0])
                                |=> s_q.ch[0].st != CH_CB_BLANK)
    else $error("short overcurrent started blanking");
  a_arm_latch: assert property ((s_q.ch[1].st == CH_CB_ARMED && oc_q[1] && !en_high[1]
                                 && !sup_uv[1] && !hi_lock && s_q.uv_ready)
                                |=> latched[1])
    else $error("armed overcurrent did not latch");
  a_ch_uv: assert property ((sup_uv[1] && !sup_uv[0] && latched[0] && !en_clr[0]
                             && s_q.uv_ready && !hi_lock && !s_q.auto_retry)
                            |=> !latched[1] && gate_pulldown_on[1]
                                && latched[0])
    else $error("channel undervoltage handled wrongly");
  a_hi_lock: assert property (hi_lock |=> s_q.ch[0].st == CH_OFF
                                          && s_q.ch[1].st == CH_OFF)
    else $error("lockout did not turn both off");
  a_fault_pin: assert property ((latched[0] || latched[1]) |-> fault_n_oe && !fault_n_o)
    else $error("fault output not pulled low");

  c_reach_idle: cover property (s_q.ch[0].st == CH_START ##1 s_q.ch[0].st == CH_IDLE);
  c_reach_latch: cover property (s_q.ch[0].st == CH_CB_ARMED ##1 latched[0]);
  c_fault_clear: cover property (latched[1] ##1 s_q.ch[1].st == CH_OFF);
  c_apb_write: cover property (wr_en && paddr == CTRL_OFS);

endmodule

// File: verilog/dlss_pkg.sv
// dlss_pkg: constants and types for the dual load switch sequencer.
// assumes a 10 MHz pclk and a 1 us internal time base tick.
package dlss_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_US       = TICK_NS / 1000;

  // delays in their own units
  localparam int UV_DELAY_MS   = 160;
  localparam int DEBOUNCE_MS   = 10;
  localparam int BLANK_MS      = 5;
  localparam int COOL_S        = 4;
  localparam int OC_FILT_US    = 100;
  localparam int CH_UV_US      = 8;
  localparam int HI_UV_US      = 12;
  localparam int EN_CLR_US     = 20;

  // the same delays in time base ticks
  localparam int UV_TICKS      = UV_DELAY_MS * 1000 / TICK_US;
  localparam int DEB_TICKS     = DEBOUNCE_MS * 1000 / TICK_US;
  localparam int BLANK_TICKS   = BLANK_MS * 1000 / TICK_US;
  localparam int COOL_TICKS    = COOL_S * 1000000 / TICK_US;
  localparam int OC_TICKS      = (OC_FILT_US + TICK_US - 1) / TICK_US;
  localparam int CH_UV_TICKS   = (CH_UV_US + TICK_US - 1) / TICK_US;
  localparam int HI_UV_TICKS   = (HI_UV_US + TICK_US - 1) / TICK_US;
  localparam int EN_CLR_TICKS  = (EN_CLR_US + TICK_US - 1) / TICK_US;

  localparam int TMR_W         = 23;
  localparam int FLT_W         = 7;
  localparam int PRE_W         = 4;
  localparam int NCH           = 2;

  // apb register map
  localparam int ADDR_W        = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam int CTRL_RETRY_BIT = 0;
  localparam logic CTRL_RETRY_RST = 1'h0;
  localparam int ST_UV_BIT     = 0;
  localparam int ST_FLT_LSB    = 1;
  localparam int ST_DRV_LSB    = 3;
  localparam int ST_DEB_LSB    = 5;

  typedef enum logic [2:0] {
    CH_OFF, CH_DEBOUNCE, CH_START, CH_IDLE, CH_CB_BLANK, CH_CB_ARMED, CH_LATCHED
  } dlss_chst_t;

  typedef struct packed {
    dlss_chst_t       st;
    logic [TMR_W-1:0] cnt;
    logic             drive;
    logic             pdn;
    logic             fast;
  } dlss_ch_t;

endpackage

// File: verilog/dlss_flt_if.sv
// dlss_flt_if: one asynchronous input, the time base tick, and its filtered views.
// assumes the filter and its user share pclk.
`timescale 1ns/1ps
interface dlss_flt_if;
  logic raw;
  logic tick;
  logic level;
  logic qual;
  modport filt (input raw, input tick, output level, output qual);
  modport user (output raw, output tick, input level, input qual);
endinterface

// File: verilog/dlss_filter.sv
// dlss_filter: two flop synchroniser and persistence qualifier.
// assumes raw is asynchronous; qual rises once level held for N ticks.
`timescale 1ns/1ps
module dlss_filter
  import dlss_pkg::*;
#(
  parameter int N = 1
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  dlss_flt_if.filt    f
);
  import dlss_pkg::*;

  localparam logic [FLT_W-1:0] LAST = FLT_W'(N);

  typedef struct packed {
    logic             s1;
    logic             s2;
    logic [FLT_W-1:0] cnt;
    logic             qual;
  } dlss_flt_t;

  dlss_flt_t s_q;
  dlss_flt_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.s1   = f.raw;
    s_d.s2   = s_q.s1;
    if (!s_q.s2) begin
      s_d.cnt = '0;
    end else if (f.tick && s_q.cnt != LAST) begin
      s_d.cnt = s_q.cnt + FLT_W'(1);
    end
    s_d.qual = s_q.s2 && (s_d.cnt == LAST);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign f.level = s_q.s2;
  assign f.qual  = s_q.qual;

endmodule

// File: verification/dlss_partner.sv
// dlss_partner: external pass switches, breaker comparators and fault line pull-up.
// assumes gate outputs of dlss_top and a short request per channel from the bench.
`timescale 1ns/1ps
module dlss_partner (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [dlss_pkg::NCH-1:0] short_req,
  input  wire logic [dlss_pkg::NCH-1:0] gate_charge_on,
  input  wire logic [dlss_pkg::NCH-1:0] gate_pulldown_on,
  input  wire logic                    fault_n_o,
  input  wire logic                    fault_n_oe,
  output logic      [dlss_pkg::NCH-1:0] breaker_trip,
  output wire logic                    fault_line
);
  import dlss_pkg::*;
  logic [NCH-1:0] sw_on_q;
  // only a conducting switch carries load current, so only it can trip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_on_q      <= '0;
      breaker_trip <= '0;
    end else begin
      sw_on_q      <= gate_charge_on & ~gate_pulldown_on;
      breaker_trip <= short_req & sw_on_q;
    end
  end
  // open-drain line, pulled up when nobody drives it
  assign fault_line = fault_n_oe ? fault_n_o : 1'b1;
endmodule

// File: verification/dlss_top_tb.sv
// dlss_top_tb: self-checking bench for the dual load switch sequencer.
// assumes shortened delays through the top parameters and the partner model.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
`define WAITU(c, n, nm) begin k = 0; while (!(c) && k < (n)) begin cyc(1); k++; end \
  `CHK(nm, 1'b1, (c)) end
module dlss_top_tb;
  import dlss_pkg::*;
  typedef struct {logic wr; logic [ADDR_W-1:0] a; logic [31:0] d; logic [31:0] r;
                  logic e;} dlss_row_t;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, vhi = 1;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd;
  logic              pready, pslverr, f_o, f_oe, fline, err;
  logic [NCH-1:0]    sup = '1, en_n = '1, sev = '0, shrt = '0, trip, chg, pdn, fast;
  int                failures = 0, n_compared = 0, k;
  dlss_row_t rows [8] = '{
    '{0, CTRL_OFS, 0, 0, 0}, '{1, CTRL_OFS, 32'h0000_0001, 0, 0}, '{0, CTRL_OFS, 0, 1, 0},
    '{1, CTRL_OFS, 0, 0, 0}, '{1, STATUS_OFS, 32'hffff_ffff, 0, 1},
    '{0, 12'h008, 0, 0, 1}, '{1, 12'h008, 32'h0000_0001, 0, 1}, '{0, CTRL_OFS, 0, 0, 0}};

  dlss_top #(.UV_T(20), .DEB_T(10), .BLANK_T(8), .COOL_T(30)) dlss_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vcc_hi_ok(vhi), .channel_supply_ok(sup), .chan_enable_n(en_n), .breaker_trip(trip),
    .severe_short(sev), .gate_charge_on(chg), .gate_pulldown_on(pdn),
    .gate_fast_pulldown_on(fast), .fault_n_o(f_o), .fault_n_oe(f_oe));
  dlss_partner dlss_partner_i (
    .pclk(pclk), .presetn(presetn), .short_req(shrt), .gate_charge_on(chg),
    .gate_pulldown_on(pdn), .fault_n_o(f_o), .fault_n_oe(f_oe), .breaker_trip(trip),
    .fault_line(fline));

  always #50 pclk = ~pclk;

  task cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task done(input string s);
    $display("test %s done", s);
  endtask

  task results;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    results();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    #1;
    `CHK("pdn rst", 2'b11, pdn)
    `CHK("oe rst", 1'b0, f_oe)
    done("reset");
    @(posedge pclk);
    en_n <= '0;
    shrt <= 2'b01;
    for (int i = 0; i < 8; i++) begin
      apb(rows[i].wr, rows[i].a, rows[i].d, rd, err);
      if (!rows[i].wr) `CHK("prdata", rows[i].r, rd)
      `CHK("pslverr", rows[i].e, err)
    end
    done("registers");
    cyc(150);
    `CHK("chg uv", 2'b00, chg)
    `WAITU(chg == 2'b11, 400, "turn on")
    @(posedge pclk);
    sev <= 2'b01;
    cyc(5);
    `CHK("fast", 2'b01, fast)
    @(posedge pclk);
    sev <= '0;
    apb(0, STATUS_OFS, 0, rd, err);
    `CHK("status", 32'h1 | (32'h3 << ST_DRV_LSB), rd)
    `CHK("pdn blank", 2'b00, pdn)
    `WAITU(f_oe, 120, "start latch")
    `CHK("chg latch", 2'b10, chg)
    `CHK("pdn latch", 2'b01, pdn)
    `CHK("line low", 1'b0, fline)
    done("start-up short");
    @(posedge pclk);
    sup <= 2'b01;
    cyc(150);
    `CHK("chg uv1", 2'b00, chg)
    `CHK("oe uv1", 1'b1, f_oe)
    @(posedge pclk);
    sup <= '1;
    `WAITU(chg[1], 300, "ch1 back")
    done("channel undervoltage");
    @(posedge pclk);
    en_n <= 2'b01;
    shrt <= '0;
    cyc(100);
    `CHK("oe short en", 1'b1, f_oe)
    @(posedge pclk);
    en_n <= '0;
    cyc(5);
    @(posedge pclk);
    en_n <= 2'b01;
    cyc(300);
    `CHK("oe cleared", 1'b0, f_oe)
    `CHK("line high", 1'b1, fline)
    @(posedge pclk);
    en_n <= '0;
    cyc(60);
    @(posedge pclk);
    en_n <= 2'b01;
    cyc(10);
    @(posedge pclk);
    en_n <= '0;
    cyc(60);
    `CHK("deb restart", 1'b0, chg[0])
    `WAITU(chg[0], 100, "ch0 back")
    done("enable clear");
    cyc(100);
    apb(1, CTRL_OFS, 32'h0000_0001, rd, err);
    @(posedge pclk);
    shrt <= 2'b01;
    cyc(500);
    @(posedge pclk);
    shrt <= '0;
    cyc(200);
    `CHK("glitch", 1'b0, f_oe)
    @(posedge pclk);
    shrt <= 2'b01;
    cyc(1040);
    `CHK("in blank", 1'b0, f_oe)
    `WAITU(f_oe, 300, "breaker")
    @(posedge pclk);
    shrt <= '0;
    cyc(100);
    `CHK("cooling", 1'b1, f_oe)
    `WAITU(!f_oe, 400, "retry")
    done("overcurrent");
    `WAITU(chg[0], 300, "ch0 retry on")
    cyc(100);
    @(posedge pclk);
    shrt <= 2'b01;
    cyc(1040);
    @(posedge pclk);
    shrt <= '0;
    cyc(200);
    @(posedge pclk);
    shrt <= 2'b01;
    cyc(1040);
    `CHK("fresh blank", 1'b0, f_oe)
    @(posedge pclk);
    shrt <= '0;
    en_n <= 2'b01;
    cyc(5);
    `CHK("en off", 2'b10, chg)
    `CHK("en pdn", 2'b01, pdn)
    done("quiet window");
    @(posedge pclk);
    presetn <= 0;
    cyc(3);
    `CHK("chg mid rst", 2'b00, chg)
    `CHK("pdn mid rst", 2'b11, pdn)
    @(posedge pclk);
    presetn <= 1;
    apb(0, CTRL_OFS, 0, rd, err);
    `CHK("retry rst", 32'h0000_0000, rd)
    `WAITU(chg == 2'b10, 400, "ch1 after rst")
    done("mid reset");
    @(posedge pclk);
    vhi <= 0;
    cyc(200);
    `CHK("chg lock", 2'b00, chg)
    `CHK("pdn lock", 2'b11, pdn)
    @(posedge pclk);
    vhi <= 1;
    cyc(150);
    `CHK("chg uv wait", 2'b00, chg)
    done("lockout");
    results();
  end
endmodule
